// ### src/slc_regs.svh
// Bit positions, reset values and timing counts of the latch control block.
// Assumes inclusion by bare name from the package and the design modules.
//
// What this block does
// - Select bits zero-zero send the word to the control latch.
// - Select bits high-low send the word to the feedback divider latch.
// - Select bits low-high send the word to the reference divider latch.
// - Arm bit set with sync select clear powers down at once.
// - Both power-down bits set power down on second reference edge.
// - Chip enable low disables the device regardless of power-down bits.
// - Power-down loads counters, tristates pump and outputs, clears lock.
// - Gain bit one picks pump setting two, zero picks setting one.
// - Gain bit follows the latest write from control or feedback latch.
// - Mute-until-lock keeps RF outputs off until lock is reported.
// - Pump tristate bit set forces the charge pump into three-state.
// - Polarity bit one gives positive detector polarity, zero negative.
// - Counter reset bit holds reference and feedback counters in reset.
// - Swallow count is a five-bit field taking zero through 31.
// - Main count is thirteen bits, dividing 3 through 8191.
// - Feedback division equals prescaler modulus times main plus swallow.
// - Bit 22 enables divide-by-two output; bit 23 feeds it to prescaler.
// - Reference divider is fourteen bits, dividing 1 through 16383.
// - Lock needs five good cycles with bit 18 set, else three.
// - Band select clock is the reference output, optionally divided down.
// - Host shifts 24 bits on rising serial clock; strobe high transfers.
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

`define SLC_WORD_W 24
`define SLC_SEL_CTRL 2'h0
`define SLC_SEL_FDIV 2'h2
`define SLC_SEL_RDIV 2'h1
// Control latch fields
`define SLC_CTL_CNT_RST 4
`define SLC_CTL_PUMP_TRI 7
`define SLC_CTL_POLARITY 8
`define SLC_CTL_GAIN 10
`define SLC_CTL_MUTE 11
`define SLC_CTL_SET1_LO 14
`define SLC_CTL_SET2_LO 17
`define SLC_CTL_PD_ARM 20
`define SLC_CTL_PD_SYNC 21
`define SLC_CTL_PRE_LO 22
// Feedback latch fields
`define SLC_FDV_SWAL_LO 2
`define SLC_FDV_MAIN_LO 8
`define SLC_FDV_GAIN 21
`define SLC_FDV_DIV2 22
`define SLC_FDV_DIV2_SEL 23
// Reference latch fields
`define SLC_RDV_DIV_LO 2
`define SLC_RDV_LOCK_PREC 18
`define SLC_RDV_BAND_LO 20
// Reset values
`define SLC_RST_WORD 24'h000000
// Lock counts and power-down edge count
`define SLC_LOCK_FINE 3'h5
`define SLC_LOCK_COARSE 3'h3
`define SLC_PD_EDGES 2'h2

`endif

// ### src/slc_pkg.sv
// Types shared by the latch control modules.
// Assumes slc_regs.svh sits on the include path.
`include "slc_regs.svh"

package slc_pkg;

	typedef logic [`SLC_WORD_W-1:0] slc_word_t;

	// Decoded settings driven to the analog and divider sections
	typedef struct packed {
		logic [2:0] pump_current;
		logic pump_tristate;
		logic polarity_pos;
		logic [1:0] prescaler_modulus_sel;
		logic div2_out_en;
		logic div2_to_prescaler;
		logic [4:0] swallow_count_bits;
		logic [12:0] main_count_bits;
		logic [13:0] ref_divide_bits;
	} slc_settings_s;

	typedef enum logic [1:0] {
		SLC_RUN,
		SLC_SYNC_WAIT,
		SLC_DOWN
	} slc_pd_e;

endpackage : slc_pkg

// ### src/slc_shift_in.sv
// Serial input register: 24 bits shifted MSB first on the clock edge.
// Assumes serial pins are already synchronised into the clk_in domain.
`timescale 1ns/10ps
`default_nettype none
`include "slc_regs.svh"

module slc_shift_in
	import slc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Synchronised serial pins
	input wire logic sclk_in,
	input wire logic sdata_in,
	input wire logic strobe_in,
	// Word out
	output slc_word_t word_out,
	output logic load_out
);

	logic sclk_d;
	logic strobe_d;
	wire sclk_rise = sclk_in & ~sclk_d;
	// Load pulse on strobe rising edge
	assign load_out = strobe_in & ~strobe_d;

	// Shift keeps running in power-down; only reset stops it
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sclk_d <= 1'b0;
			strobe_d <= 1'b0;
			word_out <= `SLC_RST_WORD;
		end else begin
			sclk_d <= sclk_in;
			strobe_d <= strobe_in;
			if (sclk_rise) begin
				word_out <= {word_out[`SLC_WORD_W-2:0], sdata_in};
			end
		end
	end

endmodule : slc_shift_in

`default_nettype wire

// ### src/slc_lock_detect.sv
// Lock qualifier: counts consecutive good reference cycles.
// Assumes phase_ok_in is from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "slc_regs.svh"

module slc_lock_detect
	import slc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Qualification inputs
	input wire logic clear_in,
	input wire logic ref_tick_in,
	input wire logic phase_ok_in,
	input wire logic fine_in,
	// Lock out
	output logic locked_out
);

	logic [2:0] good_cnt;
	wire [2:0] need = fine_in ? `SLC_LOCK_FINE : `SLC_LOCK_COARSE;

	// A bad cycle restarts the count; clear wins
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			good_cnt <= 3'h0;
			locked_out <= 1'b0;
		end else if (clear_in) begin
			good_cnt <= 3'h0;
			locked_out <= 1'b0;
		end else if (ref_tick_in) begin
			if (!phase_ok_in) begin
				good_cnt <= 3'h0;
				locked_out <= 1'b0;
			end else if (good_cnt < need) begin
				good_cnt <= good_cnt + 3'h1;
				locked_out <= (good_cnt + 3'h1) >= need;
			end
		end
	end

	a_lock_needs_cnt: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		$rose(locked_out) |-> good_cnt == need)
		else $error("lock too early");

endmodule : slc_lock_detect

`default_nettype wire

// ### src/slc_latch_ctrl.sv
// Top of the synthesizer latch control: serial capture, three latches,
// power-down control, gain tracking, mute, lock and band select clock.
// Assumes serial pins, chip enable and reference tick arrive from outside
// clk_in and are synchronised here; the phase comparator flag is local.
`timescale 1ns/10ps
`default_nettype none
`include "slc_regs.svh"

module slc_latch_ctrl
	import slc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Serial programming pins
	input wire logic sclk_in,
	input wire logic sdata_in,
	input wire logic latch_strobe_in,
	// Chip enable pin
	input wire logic chip_en_in,
	// Reference divider output and phase flag
	input wire logic ref_out_in,
	input wire logic phase_ok_in,
	// Decoded settings
	output slc_settings_s settings_out,
	output logic gain_bit_out,
	// Power and lock status
	output logic powered_down_out,
	output logic counters_load_out,
	output logic ref_buf_en_out,
	output logic rf_out_en_out,
	output logic locked_out,
	// Band select clock enable pulse
	output logic band_clk_out
);

	// Two-flop synchronisers for pins
	logic [4:0] sync1;
	logic [4:0] sync2;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
		end else begin
			sync1 <= {sclk_in, sdata_in, latch_strobe_in, chip_en_in,
				ref_out_in};
			sync2 <= sync1;
		end
	end
	wire s_sclk = sync2[4];
	wire s_data = sync2[3];
	wire s_strobe = sync2[2];
	wire s_ce = sync2[1];
	wire s_ref = sync2[0];

	// Reference edge detect
	logic ref_d;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ref_d <= 1'b0;
		end else begin
			ref_d <= s_ref;
		end
	end
	wire ref_rise = s_ref & ~ref_d;

	// Serial capture
	slc_word_t shift_word;
	logic load;
	slc_shift_in u_shift (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.sclk_in(s_sclk),
		.sdata_in(s_data),
		.strobe_in(s_strobe),
		.word_out(shift_word),
		.load_out(load)
	);

	// Latch select decode from the two last bits
	wire [1:0] sel = shift_word[1:0];
	wire ld_ctrl = load && (sel == `SLC_SEL_CTRL);
	wire ld_fdiv = load && (sel == `SLC_SEL_FDIV);
	wire ld_rdiv = load && (sel == `SLC_SEL_RDIV);

	// The three latches; select code 11 is left alone
	slc_word_t control_word_latch;
	slc_word_t feedback_divider_latch;
	slc_word_t reference_divider_latch;
	logic gain;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			control_word_latch <= `SLC_RST_WORD;
			feedback_divider_latch <= `SLC_RST_WORD;
			reference_divider_latch <= `SLC_RST_WORD;
		end else begin
			if (ld_ctrl) begin
				control_word_latch <= shift_word;
			end
			if (ld_fdiv) begin
				feedback_divider_latch <= shift_word;
			end
			if (ld_rdiv) begin
				reference_divider_latch <= shift_word;
			end
		end
	end

	// Shared gain bit: the latest writer wins
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gain <= 1'b0;
		end else if (ld_ctrl) begin
			gain <= shift_word[`SLC_CTL_GAIN];
		end else if (ld_fdiv) begin
			gain <= shift_word[`SLC_FDV_GAIN];
		end
	end
	assign gain_bit_out = gain;

	// Power-down state machine
	slc_pd_e pd_state;
	slc_pd_e next_pd_state;
	logic [1:0] pd_edges;

	// Requests carried by a control write; a later write overrides an
	// earlier one that is still waiting for its reference edges
	wire pd_arm_bit = shift_word[`SLC_CTL_PD_ARM];
	wire pd_sync_bit = shift_word[`SLC_CTL_PD_SYNC];
	wire pd_cancel = ld_ctrl && !pd_arm_bit;
	wire pd_req_async = ld_ctrl && pd_arm_bit && !pd_sync_bit;
	wire pd_req_sync = ld_ctrl && pd_arm_bit && pd_sync_bit;
	wire pd_second_edge = ref_rise && (pd_edges == `SLC_PD_EDGES - 2'h1);

	// Next state; a sync request while already down keeps the part down
	always_comb begin
		next_pd_state = pd_state;
		unique case (pd_state)
			SLC_RUN: begin
				if (pd_req_async) begin
					next_pd_state = SLC_DOWN;
				end else if (pd_req_sync) begin
					next_pd_state = SLC_SYNC_WAIT;
				end
			end
			SLC_SYNC_WAIT: begin
				if (pd_cancel) begin
					next_pd_state = SLC_RUN;
				end else if (pd_req_async) begin
					next_pd_state = SLC_DOWN;
				end else if (!pd_req_sync && pd_second_edge) begin
					next_pd_state = SLC_DOWN;
				end
			end
			SLC_DOWN: begin
				if (pd_cancel) begin
					next_pd_state = SLC_RUN;
				end
			end
		endcase
	end

	// Edge counter resets on each strobe into the waiting state
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pd_state <= SLC_RUN;
			pd_edges <= 2'h0;
		end else begin
			pd_state <= next_pd_state;
			if (pd_state != SLC_SYNC_WAIT || ld_ctrl) begin
				pd_edges <= 2'h0;
			end else if (ref_rise) begin
				pd_edges <= pd_edges + 2'h1;
			end
		end
	end

	// Chip enable low overrides any software state
	wire pd_any = !s_ce || (pd_state == SLC_DOWN);
	wire cnt_rst = control_word_latch[`SLC_CTL_CNT_RST];

	// Lock detector, cleared in power-down
	logic lock;
	slc_lock_detect u_lock (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.clear_in(pd_any),
		.ref_tick_in(ref_rise),
		.phase_ok_in(phase_ok_in),
		.fine_in(reference_divider_latch[`SLC_RDV_LOCK_PREC]),
		.locked_out(lock)
	);
	assign locked_out = lock;

	// Power-down effects and mute; outputs as registers
	wire mute = control_word_latch[`SLC_CTL_MUTE] && !lock;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			powered_down_out <= 1'b1;
			counters_load_out <= 1'b1;
			ref_buf_en_out <= 1'b0;
			rf_out_en_out <= 1'b0;
		end else begin
			powered_down_out <= pd_any;
			counters_load_out <= pd_any || cnt_rst;
			ref_buf_en_out <= !pd_any;
			rf_out_en_out <= !pd_any && !mute;
		end
	end

	// Decoded settings; pump current picked by gain bit
	wire [2:0] set1 = control_word_latch[`SLC_CTL_SET1_LO +: 3];
	wire [2:0] set2 = control_word_latch[`SLC_CTL_SET2_LO +: 3];
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			settings_out <= '0;
		end else begin
			settings_out.pump_current <= gain ? set2 : set1;
			settings_out.pump_tristate <= pd_any ||
				control_word_latch[`SLC_CTL_PUMP_TRI];
			settings_out.polarity_pos <=
				control_word_latch[`SLC_CTL_POLARITY];
			settings_out.prescaler_modulus_sel <=
				control_word_latch[`SLC_CTL_PRE_LO +: 2];
			settings_out.div2_out_en <= feedback_divider_latch[`SLC_FDV_DIV2];
			settings_out.div2_to_prescaler <=
				feedback_divider_latch[`SLC_FDV_DIV2_SEL];
			settings_out.swallow_count_bits <=
				feedback_divider_latch[`SLC_FDV_SWAL_LO +: 5];
			settings_out.main_count_bits <=
				feedback_divider_latch[`SLC_FDV_MAIN_LO +: 13];
			settings_out.ref_divide_bits <=
				reference_divider_latch[`SLC_RDV_DIV_LO +: 14];
		end
	end

	// Band select clock: divide reference ticks by 1, 2, 4 or 8
	logic [2:0] band_cnt;
	wire [1:0] band_sel = reference_divider_latch[`SLC_RDV_BAND_LO +: 2];
	wire [2:0] band_max = 3'((4'h1 << band_sel) - 4'h1);
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			band_cnt <= 3'h0;
			band_clk_out <= 1'b0;
		end else begin
			band_clk_out <= 1'b0;
			if (pd_any) begin
				band_cnt <= 3'h0;
			end else if (ref_rise) begin
				if (band_cnt >= band_max) begin
					band_cnt <= 3'h0;
					band_clk_out <= 1'b1;
				end else begin
					band_cnt <= band_cnt + 3'h1;
				end
			end
		end
	end

	// Checks: latch transfer by select code
	a_ctrl_load: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		ld_ctrl |=> control_word_latch == $past(shift_word))
		else $error("control latch not loaded");
	a_fdiv_load: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		ld_fdiv |=> feedback_divider_latch == $past(shift_word))
		else $error("feedback latch not loaded");
	a_rdiv_load: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		ld_rdiv |=> reference_divider_latch == $past(shift_word))
		else $error("reference latch not loaded");
	a_spare_select: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		(load && sel == 2'h3) |=> $stable(control_word_latch) &&
			$stable(feedback_divider_latch) &&
			$stable(reference_divider_latch) && $stable(gain))
		else $error("spare select code wrote a latch");

	// Checks: power-down entry and its effects
	a_async_pd: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		(ld_ctrl && shift_word[20] && !shift_word[21]) |=> ##1 powered_down_out)
		else $error("async power-down late");
	a_sync_pd_wait: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		(pd_state == SLC_SYNC_WAIT && s_ce) |=> !powered_down_out)
		else $error("sync power-down too early");
	a_sync_pd_edge: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		(pd_state == SLC_SYNC_WAIT && pd_edges == 2'h1 && ref_rise &&
			!ld_ctrl) |=> ##1 powered_down_out)
		else $error("sync power-down missed second edge");
	a_ce_forces_pd: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		!s_ce |=> powered_down_out && !rf_out_en_out && settings_out.pump_tristate)
		else $error("chip enable ignored");
	a_pd_effects: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		pd_any |=> counters_load_out && !ref_buf_en_out && !locked_out &&
			settings_out.pump_tristate && !rf_out_en_out)
		else $error("power-down effects missing");
	a_run_bias: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		!pd_any |=> ref_buf_en_out && !powered_down_out)
		else $error("running block left powered down");

	// Checks: shared gain bit and the pump setting it picks
	a_gain_latest: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		ld_fdiv |=> gain_bit_out == $past(shift_word[21]))
		else $error("gain bit not tracking");
	a_gain_ctrl: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		ld_ctrl |=> gain_bit_out == $past(shift_word[10]))
		else $error("gain bit ignores control write");
	a_pump_setting: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		ld_ctrl |=> ##1 settings_out.pump_current == ($past(shift_word[10], 2) ?
			$past(shift_word[19:17], 2) : $past(shift_word[16:14], 2)))
		else $error("pump current setting wrong");

	// Checks: mute, counter reset and band select clock
	a_mute_lock: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		(control_word_latch[11] && !lock) |=> !rf_out_en_out)
		else $error("output on before lock");
	a_cnt_reset: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		cnt_rst |=> counters_load_out)
		else $error("counter reset ignored");
	a_cnt_release: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		(!pd_any && !cnt_rst) |=> !counters_load_out)
		else $error("counters held without cause");
	a_band_tick: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		band_clk_out |-> $past(ref_rise) && !$past(pd_any))
		else $error("band clock without reference tick");
	a_band_every: assert property (
		@(posedge clk_in) disable iff (!arst_n_in)
		(ref_rise && !pd_any && band_sel == 2'h0) |=> band_clk_out)
		else $error("undivided band clock missed a tick");

endmodule : slc_latch_ctrl

`default_nettype wire

// ### bench/slc_host_model.sv
// Host model: shifts 24-bit words onto the serial pins, then strobes.
// Assumes go_in and word_in hold until done_out is seen high.
`timescale 1ns/10ps
`default_nettype none

module slc_host_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Request
	input wire logic go_in,
	input wire logic [23:0] word_in,
	// Serial pins and completion
	output logic sclk_out,
	output logic sdata_out,
	output logic strobe_out,
	output logic done_out
);
	logic busy;
	logic [7:0] t;

	// Eight clocks a bit keep sclk high and low past the sync filter
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{busy, done_out, sclk_out, sdata_out, strobe_out} <= 5'h00;
			t <= 8'h00;
		end else if (!busy) begin
			done_out <= 1'b0;
			sdata_out <= ~sdata_out; // Idle line toggles, no stale bit
			busy <= go_in && !done_out;
			t <= 8'h00;
		end else begin
			t <= t + 8'h01;
			sclk_out <= t < 8'hC0 && t[2:0] >= 3'h3 && t[2:0] != 3'h7;
			if (t < 8'hC0 && t[2:0] == 3'h0)
				sdata_out <= word_in[23 - t[7:3]];
			else if (t >= 8'hC0)
				sdata_out <= ~sdata_out;
			strobe_out <= t >= 8'hC0 && t < 8'hC4;
			if (t == 8'hC7) begin
				busy <= 1'b0;
				done_out <= 1'b1;
			end
		end
	end
endmodule : slc_host_model

`default_nettype wire

// ### bench/slc_latch_ctrl_tb_top.sv
// Testbench of the latch control: random and corner words, power-down,
// lock, mute and band clock. Assumes slc_pkg and the host model compiled.
`timescale 1ns/10ps
`default_nettype none

module slc_latch_ctrl_tb_top
	import slc_pkg::*;
;
	logic clk_in, arst_n_in, chip_en, ref_out, phase_ok, go, done;
	logic sclk, sdata, strobe, gain, pd, cload, rbuf, rfen, locked, band_clk;
	slc_word_t word, c_w, f_w, r_w, x;
	slc_settings_s settings;
	logic gain_sh;
	logic [7:0] band_n = 8'h00;
	logic [7:0] b0;
	integer seed, n_errors, cmp_count, i, k;
	integer cyc = 0;
	// Control-to-feedback settle gap, scaled down from the 5 ms a real
	// host waits so that the run stays short
	localparam integer SETTLE_CYC = 200;

	slc_host_model slc_host_model_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.go_in(go), .word_in(word), .sclk_out(sclk), .sdata_out(sdata),
		.strobe_out(strobe), .done_out(done));

	slc_latch_ctrl slc_latch_ctrl_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.sclk_in(sclk), .sdata_in(sdata), .latch_strobe_in(strobe),
		.chip_en_in(chip_en), .ref_out_in(ref_out), .phase_ok_in(phase_ok),
		.settings_out(settings), .gain_bit_out(gain),
		.powered_down_out(pd), .counters_load_out(cload),
		.ref_buf_en_out(rbuf), .rf_out_en_out(rfen), .locked_out(locked),
		.band_clk_out(band_clk));

	// Clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Band pulse tally and hang guard
	always @(posedge clk_in) begin
		cyc = cyc + 1;
		if (band_clk === 1'b1)
			band_n <= band_n + 8'h01;
		if (cyc == 60000) begin
			n_errors = n_errors + 1;
			end_sim();
		end
	end

	function automatic slc_settings_s exp_set();
		slc_settings_s s;
		s.pump_current = gain_sh ? c_w[19:17] : c_w[16:14];
		s.pump_tristate = c_w[7];
		s.polarity_pos = c_w[8];
		s.prescaler_modulus_sel = c_w[23:22];
		s.div2_out_en = f_w[22];
		s.div2_to_prescaler = f_w[23];
		s.swallow_count_bits = f_w[6:2];
		s.main_count_bits = f_w[20:8];
		s.ref_divide_bits = r_w[15:2];
		return s;
	endfunction : exp_set

	task automatic chk_set(input slc_settings_s e, input slc_settings_s g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("[ERR] settings exp %h got %h", e, g);
		end
	endtask : chk_set

	task automatic chk_val(input string n, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk_val

	// Whole word through the host model; shadows follow the select bits
	task automatic send(input slc_word_t w);
		@(posedge clk_in);
		go <= 1'b1;
		word <= w;
		do @(posedge clk_in); while (done !== 1'b1);
		go <= 1'b0;
		repeat (4) @(posedge clk_in);
		case (w[1:0])
			2'h0: {c_w, gain_sh} = {w, w[10]};
			2'h2: {f_w, gain_sh} = {w, w[21]};
			2'h1: r_w = w;
			default: ;
		endcase
	endtask : send

	task automatic ref_pulse();
		@(posedge clk_in);
		ref_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		ref_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : ref_pulse

	task automatic check_run();
		chk_set(exp_set(), settings);
		chk_val("gain", gain_sh, gain);
		chk_val("pd", 8'h00, pd);
		chk_val("load", c_w[4], cload);
		chk_val("rfen", !c_w[11], rfen);
		chk_val("rbuf", 8'h01, rbuf);
	endtask : check_run

	task automatic check_down();
		chk_val("pd", 8'h01, pd);
		chk_val("load", 8'h01, cload);
		chk_val("rbuf", 8'h00, rbuf);
		chk_val("rfen", 8'h00, rfen);
		chk_val("lock", 8'h00, locked);
	endtask : check_down

	task automatic lock_run(input integer n);
		phase_ok <= 1'b1;
		for (k = 1; k <= n; k++) begin
			ref_pulse();
			chk_val("lock", k == n, locked);
		end
	endtask : lock_run

	task automatic end_sim();
		$display("counts: %0d errors, %0d compares", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	// Main sequence
	initial begin
		{arst_n_in, ref_out, phase_ok, go, gain_sh} = 5'h00;
		chip_en = 1'b1;
		{word, c_w, f_w, r_w} = '0;
		{seed, n_errors, cmp_count} = {32'h45C05F0E, 64'h0};
		repeat (16) @(posedge clk_in);
		check_down();
		arst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		// Reference, control, feedback; first pass maxima, second divider minima
		for (i = 0; i < 6; i++) begin
			x = (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h000000 :
				24'($random(seed));
			send({x[23:16], i == 1 ? 14'h0001 : x[15:2], 2'h1});
			check_run();
			x = (i == 0) ? 24'hFFFFFF : 24'($random(seed));
			send({x[23:22], 2'h0, x[19:2], 2'h0});
			check_run();
			repeat (SETTLE_CYC) @(posedge clk_in);
			x = (i == 0) ? 24'hFFFFFF : 24'($random(seed));
			send({x[23:21], i == 1 ? 13'h0003 : x[20:8],
				i == 1 ? 6'h00 : x[7:2], 2'h2});
			check_run();
			x = 24'($random(seed));
			send({x[23:2], 2'h3});
			check_run();
		end
		send({c_w[23:22], 2'h1, c_w[19:2], 2'h0});
		check_down();
		send({c_w[23:22], 2'h0, c_w[19:12], 1'b1, c_w[10:5], 1'b0,
			c_w[3:2], 2'h0});
		check_run();
		send({c_w[23:22], 2'h3, c_w[19:2], 2'h0});
		chk_val("pd", 8'h00, pd);
		ref_pulse();
		chk_val("pd", 8'h00, pd);
		ref_pulse();
		check_down();
		send({c_w[23:22], 2'h0, c_w[19:2], 2'h0});
		chip_en <= 1'b0;
		repeat (6) @(posedge clk_in);
		check_down();
		chip_en <= 1'b1;
		repeat (6) @(posedge clk_in);
		check_run();
		send({r_w[23:19], 1'b1, r_w[17:2], 2'h1});
		lock_run(5);
		chk_val("rfen", 8'h01, rfen);
		phase_ok <= 1'b0;
		ref_pulse();
		chk_val("lock", 8'h00, locked);
		chk_val("rfen", 8'h00, rfen);
		send({r_w[23:19], 1'b0, r_w[17:2], 2'h1});
		lock_run(3);
		// Every band divider code over eight settled reference ticks
		for (i = 0; i < 4; i++) begin
			send({r_w[23:22], i[1:0], r_w[19:2], 2'h1});
			repeat (8) ref_pulse();
			b0 = band_n;
			repeat (8) ref_pulse();
			chk_val("band", 8'h08 >> i, band_n - b0);
		end
		end_sim();
	end
endmodule : slc_latch_ctrl_tb_top

`default_nettype wire
